// File: logic/flag_offset_pkg.sv
// Constants and types shared by the offset loader host controller.
// Assumes a 125 MHz system clock; the serial clock is derived from it.
package flag_offset_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCLK_PERIOD_NS = 80;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int MRS_LOW_NS = 100;
    localparam int MRS_LOW_CYC =
        (MRS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CFG_SETUP_CYC = 4;

    // ********************************************************
    // Chain geometry
    // ********************************************************
    localparam int NUM_FIELDS = 8;
    localparam int FIELD_W_MAX = 17;
    localparam logic [4:0] FIELD_W_BASE = 5'h0d;
    localparam logic [2:0] FIRST_SEQ = 3'h0;
    localparam logic [2:0] LAST_SEQ = 3'h7;

    // ********************************************************
    // Configuration codes
    // ********************************************************
    localparam logic [1:0] WIDTH_X40 = 2'h0;
    localparam logic [1:0] WIDTH_X20 = 2'h1;
    localparam logic [1:0] WIDTH_X10 = 2'h2;
    localparam logic [1:0] CODE_BAD = 2'h3;
    localparam logic [1:0] DEF_SEL_7 = 2'h0;
    localparam logic [1:0] DEF_SEL_63 = 2'h1;
    localparam logic [1:0] DEF_SEL_127 = 2'h2;
    localparam logic [1:0] DEF_SEL_1023 = 2'h3;

    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_RESET = 2'h2;

    typedef logic [NUM_FIELDS-1:0][FIELD_W_MAX-1:0] offsets_t;

    typedef enum logic [2:0]
    {
        S_IDLE,
        S_RST_SETUP,
        S_RST_LOW,
        S_RST_HOLD,
        S_WRITE,
        S_READ,
        S_TAIL
    } state_t;

endpackage

// File: logic/serial_clock_gen.sv
// Serial clock divider for the offset loader.
// Assumes run is a registered level from the same clock domain.
`timescale 1ns/100ps
module serial_clock_gen
    import flag_offset_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    output logic sclk,
    output logic rise_pulse,
    output logic fall_pulse
);

    typedef struct packed {
        logic [7:0] cnt;
        logic level;
        logic rise;
        logic fall;
    } gen_t;

    gen_t g_r;
    gen_t g_nxt;

    // ********************************************************
    // Divider: idles high, first edge of a run is a fall
    // ********************************************************
    always_comb
    begin
        g_nxt = g_r;
        g_nxt.rise = 1'b0;
        g_nxt.fall = 1'b0;
        if (!run)
        begin
            g_nxt.cnt = 8'(HALF_CYC - 1);
            g_nxt.level = 1'b1;
        end
        else if (g_r.cnt == 8'(HALF_CYC - 1))
        begin
            g_nxt.cnt = 8'h00;
            g_nxt.level = ~g_r.level;
            g_nxt.rise = ~g_r.level;
            g_nxt.fall = g_r.level;
        end
        else
        begin
            g_nxt.cnt = g_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            g_r <= '{cnt: 8'h00, level: 1'b1, rise: 1'b0, fall: 1'b0};
        end
        else
        begin
            g_r <= g_nxt;
        end
    end

    assign sclk = g_r.level;
    assign rise_pulse = g_r.rise;
    assign fall_pulse = g_r.fall;

endmodule // serial_clock_gen

// File: logic/flag_offset_serial_loader.sv
// Host controller that writes, reads back and resets the flag offset
// chain of a four-queue flow-control device over its serial pins.
// Assumes the device samples on serial clock rising edges.
`timescale 1ns/100ps

// Behaviour
// RULE1 - Device loads defaults from select at reset
// RULE2 - Default applies alike to all queues
// RULE3 - Per-queue values need serial programming
// RULE4 - Write enable low shifts one bit per rise
// RULE5 - Read enable low outputs one bit per rise
// RULE6 - Read enable held low whole read
// RULE7 - Device outputs zeros after chain end
// RULE8 - Chain length from width and depth
// RULE9 - Empty offset first, LSB first
// RULE10 - Chain holds all eight offset fields
// RULE11 - Host always shifts the full chain
// RULE12 - Test-port write instruction loads chain
// RULE13 - Test-port read instruction shifts chain
// RULE14 - Serial pins held high when idle
// RULE15 - Same behaviour in both timing modes
// RULE16 - Field order queue 3 empty first
// RULE17 - Flags follow programmed offsets
// RULE18 - Select steady during master reset pulse
// RULE19 - Master reset restarts chain position
module flag_offset_serial_loader
    import flag_offset_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int MRS_LOW_CYCLES = MRS_LOW_CYC,
    parameter int CFG_CYCLES = CFG_SETUP_CYC
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [1:0] cmd_width,
    input wire logic [1:0] cmd_depth,
    input wire logic [1:0] cmd_default_select,
    input wire offsets_t wr_offsets,
    output offsets_t rd_offsets,
    output logic done,
    output logic serial_clock,
    output logic serial_write_enable_n,
    output logic serial_read_enable_n,
    output logic serial_program_input,
    input wire logic serial_program_output,
    output logic master_reset_n,
    output logic [1:0] default_offset_select
);

    typedef struct packed {
        state_t st;
        logic run;
        logic serial_write_enable_n_n;
        logic serial_read_enable_n_n;
        logic si;
        logic mrs_n;
        logic [1:0] fsel;
        logic [4:0] fw;
        logic [7:0] cnt;
        logic [2:0] seq;
        logic [4:0] bitpos;
        logic [7:0] tmr;
        offsets_t hold;
        offsets_t rd;
        logic sdo_s1;
        logic sdo_s2;
        logic done;
    } ctl_t;

    ctl_t s_r;
    ctl_t s_nxt;
    logic rise_pulse;
    logic fall_pulse;
    logic sclk;
    logic [4:0] fw_in;
    logic bad_cfg;

    // Queue 3 empty first, queue 0 full last
    function automatic logic [2:0] field_idx(input logic [2:0] seq);
        field_idx = {~seq[2:1], seq[0]}; // RULE16 RULE12 RULE13
    endfunction

    serial_clock_gen #(
        .HALF_CYC(HALF_CYC)
    ) u_sclk (
        .clk(clk),
        .srst(srst),
        .run(s_r.run),
        .sclk(sclk),
        .rise_pulse(rise_pulse),
        .fall_pulse(fall_pulse)
    );

    // Field widens by one per narrower bus and per larger depth
    assign fw_in = FIELD_W_BASE + {3'h0, cmd_width}
        + {3'h0, cmd_depth}; // RULE8
    assign bad_cfg = (cmd_width == CODE_BAD) || (cmd_depth == CODE_BAD);

    // ********************************************************
    // Sequencer
    // ********************************************************
    always_comb
    begin
        logic [2:0] nseq;
        logic [4:0] nbit;
        nseq = s_r.seq;
        nbit = s_r.bitpos;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.sdo_s1 = serial_program_output;
        s_nxt.sdo_s2 = s_r.sdo_s1;
        unique case (s_r.st)
            S_IDLE:
            begin
                if (cmd_valid)
                begin
                    s_nxt.cnt = 8'h00;
                    s_nxt.seq = FIRST_SEQ;
                    s_nxt.bitpos = 5'h00;
                    s_nxt.fw = fw_in;
                    s_nxt.tmr = 8'h00;
                    if (cmd_op == OP_WRITE && !bad_cfg)
                    begin
                        // Whole chain always rewritten from the latch
                        s_nxt.st = S_WRITE; // RULE3 RULE11
                        s_nxt.hold = wr_offsets;
                        s_nxt.serial_write_enable_n_n = 1'b0;
                        s_nxt.si =
                            wr_offsets[field_idx(FIRST_SEQ)][0]; // RULE9
                        s_nxt.run = 1'b1;
                    end
                    else if (cmd_op == OP_READ && !bad_cfg)
                    begin
                        s_nxt.st = S_READ;
                        s_nxt.serial_read_enable_n_n = 1'b0; // RULE5
                        s_nxt.run = 1'b1;
                    end
                    else if (cmd_op == OP_RESET)
                    begin
                        s_nxt.st = S_RST_SETUP;
                        s_nxt.fsel = cmd_default_select;
                    end
                end
            end
            S_RST_SETUP:
            begin
                s_nxt.tmr = s_r.tmr + 8'h01;
                if (s_r.tmr == 8'(CFG_CYCLES - 1))
                begin
                    s_nxt.st = S_RST_LOW;
                    s_nxt.mrs_n = 1'b0; // RULE18
                    s_nxt.tmr = 8'h00;
                end
            end
            S_RST_LOW:
            begin
                s_nxt.tmr = s_r.tmr + 8'h01;
                if (s_r.tmr == 8'(MRS_LOW_CYCLES - 1))
                begin
                    s_nxt.st = S_RST_HOLD;
                    s_nxt.mrs_n = 1'b1;
                    s_nxt.tmr = 8'h00;
                end
            end
            S_RST_HOLD:
            begin
                s_nxt.tmr = s_r.tmr + 8'h01;
                if (s_r.tmr == 8'(CFG_CYCLES - 1))
                begin
                    s_nxt.st = S_IDLE;
                    s_nxt.seq = FIRST_SEQ; // RULE19
                    s_nxt.bitpos = 5'h00;
                    s_nxt.done = 1'b1;
                end
            end
            S_WRITE, S_READ:
            begin
                if (rise_pulse)
                begin
                    s_nxt.cnt = s_r.cnt + 8'h01; // RULE4 RULE5
                end
                if (fall_pulse && s_r.cnt != 8'h00)
                begin
                    if (s_r.st == S_READ)
                    begin
                        s_nxt.rd[field_idx(s_r.seq)][s_r.bitpos] = s_r.sdo_s2;
                    end
                    if (s_r.cnt == {s_r.fw, 3'h0})
                    begin
                        // Enables rise while the clock is low
                        s_nxt.st = S_TAIL; // RULE6 RULE8
                        s_nxt.serial_write_enable_n_n = 1'b1;
                        s_nxt.serial_read_enable_n_n = 1'b1;
                        s_nxt.si = 1'b1;
                    end
                    else
                    begin
                        if (s_r.bitpos == s_r.fw - 5'h01)
                        begin
                            nbit = 5'h00;
                            nseq = s_r.seq + 3'h1; // RULE16
                        end
                        else
                        begin
                            nbit = s_r.bitpos + 5'h01; // RULE9
                        end
                        s_nxt.seq = nseq;
                        s_nxt.bitpos = nbit;
                        if (s_r.st == S_WRITE)
                        begin
                            s_nxt.si = s_r.hold[field_idx(nseq)][nbit];
                        end
                    end
                end
            end
            S_TAIL:
            begin
                // Clock returns high with both enables already high
                if (rise_pulse)
                begin
                    s_nxt.run = 1'b0; // RULE14
                    s_nxt.st = S_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            default:
            begin
                s_nxt.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_r <= '0;
            s_r.st <= S_IDLE;
            s_r.serial_write_enable_n_n <= 1'b1; // RULE14
            s_r.serial_read_enable_n_n <= 1'b1;
            s_r.si <= 1'b1;
            s_r.mrs_n <= 1'b1;
            s_r.fw <= FIELD_W_BASE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready = (s_r.st == S_IDLE);
    assign rd_offsets = s_r.rd;
    assign done = s_r.done;
    assign serial_clock = sclk;
    assign serial_write_enable_n = s_r.serial_write_enable_n_n;
    assign serial_read_enable_n = s_r.serial_read_enable_n_n;
    assign serial_program_input = s_r.si;
    assign master_reset_n = s_r.mrs_n;
    assign default_offset_select = s_r.fsel;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_WR_ENABLES: assert property ( // RULE4
        s_r.st == S_WRITE |-> !serial_write_enable_n && serial_read_enable_n)
        else $error("write enables wrong during write");
    AST_SI_CLK_LOW: assert property ( // RULE4
        $changed(serial_program_input) && !serial_write_enable_n
            && $stable(serial_write_enable_n) |-> !serial_clock)
        else $error("serial input changed with clock high");
    AST_RD_HOLD: assert property ( // RULE6
        $fell(serial_read_enable_n) |-> !serial_read_enable_n [*8])
        else $error("read enable released early");
    AST_IDLE_PINS: assert property ( // RULE14
        s_r.st == S_IDLE |-> serial_clock && serial_write_enable_n
            && serial_read_enable_n && serial_program_input)
        else $error("serial pins not high while idle");
    AST_FIRST_BIT: assert property ( // RULE9
        $fell(serial_write_enable_n)
            |-> serial_program_input == s_r.hold[6][0])
        else $error("first bit is not queue 3 empty lsb");
    AST_CHAIN_LEN: assert property ( // RULE8
        $rose(serial_write_enable_n) || $rose(serial_read_enable_n)
            |-> s_r.cnt == {s_r.fw, 3'h0} && !serial_clock)
        else $error("transfer length differs from chain length");
    AST_MRS_SEL: assert property ( // RULE18
        !master_reset_n |-> $stable(default_offset_select))
        else $error("select moved during master reset");
    AST_MRS_WIDTH: assert property ( // RULE18
        $fell(master_reset_n) |-> !master_reset_n [*8] ##6 master_reset_n)
        else $error("master reset pulse width wrong");

    COV_WRITE: cover property (
        s_r.st == S_TAIL && $past(s_r.st) == S_WRITE);
    COV_READ: cover property (
        s_r.st == S_TAIL && $past(s_r.st) == S_READ);
    COV_RESET: cover property (
        s_r.st == S_IDLE && $past(s_r.st) == S_RST_HOLD);

endmodule // flag_offset_serial_loader

// File: sim/offset_device_model.sv
// Behavioural model of the device's flag offset chain and serial port.
// Assumes the bench gives the field width that the device was built for.
`timescale 1ns/100ps
module offset_device_model
(
    input wire logic serial_clock,
    input wire logic serial_write_enable_n,
    input wire logic serial_read_enable_n,
    input wire logic serial_program_input,
    output logic serial_program_output,
    input wire logic master_reset_n,
    input wire logic [1:0] default_offset_select,
    input wire logic [4:0] fw
);
    // ********************************************************
    // Chain held in stream order: queue 3 empty LSB first
    // ********************************************************
    logic chain [0:135];
    logic [16:0] dv;
    int pos = 0;
    initial serial_program_output = 1'b1;
    always_comb
    begin
        case (default_offset_select)
            2'h0: dv = 17'h0_0007;
            2'h1: dv = 17'h0_003f;
            2'h2: dv = 17'h0_007f;
            default: dv = 17'h0_03ff;
        endcase
    end
    always @(negedge master_reset_n)
    begin
        pos = 0;
        for (int i = 0; i < 136; i++)
            chain[i] = dv[i % fw];
    end
    // Position restarts when the host raises either enable
    always @(posedge serial_write_enable_n or posedge serial_read_enable_n)
        pos = 0;
    always @(posedge serial_read_enable_n)
        serial_program_output <= ~serial_program_output;
    always @(posedge serial_clock)
    begin
        if (!serial_write_enable_n && pos < 8 * fw)
        begin
            chain[pos] = serial_program_input;
            pos++;
        end
        else if (!serial_read_enable_n)
        begin
            serial_program_output <= (pos < 8 * fw) ?
                chain[pos] : 1'b0;
            pos++;
        end
    end
endmodule // offset_device_model

// File: sim/flag_offset_serial_loader_tb.sv
// Self-checking bench for the offset loader host controller.
// Assumes the device model stands on the serial pins.
`timescale 1ns/100ps
module flag_offset_serial_loader_tb
    import flag_offset_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [1:0] cmd_width = 2'h0;
    logic [1:0] cmd_depth = 2'h0;
    logic [1:0] cmd_default_select = 2'h0;
    offsets_t wr_offsets = '0;
    offsets_t rd_offsets;
    logic cmd_ready, done, serial_clock, serial_write_enable_n;
    logic serial_read_enable_n, serial_program_input;
    logic serial_program_output, master_reset_n;
    logic [1:0] default_offset_select;
    logic [4:0] dev_fw = 5'h0d;
    logic exp_bits [0:135];
    logic wbits [0:135];
    logic [15:0] seed = 16'h4533;
    logic [1:0] w, d;
    int nw, nr, cyc, n_errors, n_checks;

    always #4 clk = ~clk;

    flag_offset_serial_loader dut (.clk, .srst, .cmd_valid, .cmd_ready,
        .cmd_op, .cmd_width, .cmd_depth, .cmd_default_select, .wr_offsets,
        .rd_offsets, .done, .serial_clock, .serial_write_enable_n,
        .serial_read_enable_n, .serial_program_input, .serial_program_output,
        .master_reset_n, .default_offset_select);
    offset_device_model device (.serial_clock, .serial_write_enable_n,
        .serial_read_enable_n, .serial_program_input, .serial_program_output,
        .master_reset_n, .default_offset_select, .fw(dev_fw));

    always @(posedge serial_clock)
    begin
        if (serial_write_enable_n === 1'b0 && nw < 136)
        begin
            wbits[nw] = serial_program_input;
            nw++;
        end
        if (serial_read_enable_n === 1'b0)
            nr++;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [16:0] def_offset(input logic [1:0] sel);
        case (sel)
            DEF_SEL_7: return 17'h0_0007;
            DEF_SEL_63: return 17'h0_003f;
            DEF_SEL_127: return 17'h0_007f;
            default: return 17'h0_03ff;
        endcase
    endfunction

    task automatic pick(output logic [1:0] v);
        seed = nxt(seed);
        v = 2'(seed % 3);
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ********************************************************
    // Command, write, read and reset sequences
    // ********************************************************
    task automatic run(input logic [1:0] op, wi, de, s, input logic take);
        logic bad;
        bad = 1'b0;
        cmd_op <= op;
        cmd_width <= wi;
        cmd_depth <= de;
        cmd_default_select <= s;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        if (take)
        begin
            for (int k = 0; k < 3000 && done !== 1'b1; k++)
                @(posedge clk);
            chk(17'(done), 17'h0_0001);
            @(posedge clk);
            chk(17'({serial_clock, serial_write_enable_n,
                serial_read_enable_n, serial_program_input}),
                17'h0_000f);
        end
        else
        begin
            repeat (20)
            begin
                @(posedge clk);
                if (cmd_ready !== 1'b1 || done === 1'b1)
                    bad = 1'b1;
            end
            chk(17'(bad), 17'h0_0000);
        end
    endtask

    task automatic read_chk(input logic [1:0] wi, de);
        int f;
        logic [16:0] e;
        f = 13 + wi + de;
        nr = 0;
        run(OP_READ, wi, de, 2'h0, 1'b1);
        chk(17'(nr), 17'(8 * f));
        for (int s = 0; s < 8; s++)
        begin
            e = '0;
            for (int k = 0; k < f; k++)
                e[k] = exp_bits[s * f + k];
            chk(rd_offsets[{~s[2:1], s[0]}] & 17'((1 << f) - 1), e);
        end
    endtask

    task automatic write_chk(input logic [1:0] wi, de);
        int f;
        offsets_t v;
        logic [2:0] q;
        logic bad;
        f = 13 + wi + de;
        bad = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            seed = nxt(seed);
            v[i][15:0] = seed;
            seed = nxt(seed);
            v[i][16] = seed[0];
        end
        for (int i = 0; i < 136; i++)
        begin
            q = 3'(i / f);
            exp_bits[i] = (i < 8 * f) ? v[{~q[2:1], q[0]}][i % f] : 1'b0;
        end
        wr_offsets <= v;
        dev_fw <= 5'(f);
        nw = 0;
        run(OP_WRITE, wi, de, 2'h0, 1'b1);
        chk(17'(nw), 17'(8 * f));
        for (int i = 0; i < 8 * f; i++)
            if (wbits[i] !== exp_bits[i])
                bad = 1'b1;
        chk(17'(bad), 17'h0_0000);
    endtask

    task automatic mreset(input logic [1:0] sel, input int f);
        logic [16:0] dv;
        dv = def_offset(sel);
        dev_fw <= 5'(f);
        run(OP_RESET, 2'h0, 2'h0, sel, 1'b1);
        for (int i = 0; i < 136; i++)
            exp_bits[i] = (i < 8 * f) ? dv[i % f] : 1'b0;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_errors++;
            results();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            pick(w);
            pick(d);
            mreset(2'(s), 13 + w + d);
            read_chk(w, d);
        end
        $display("default select test done");
        repeat (3)
        begin
            pick(w);
            pick(d);
            write_chk(w, d);
            read_chk(w, d);
        end
        $display("write and read-back test done");
        mreset(2'h2, 13);
        read_chk(2'h2, 2'h2);
        $display("read past chain end test done");
        run(2'h3, 2'h0, 2'h0, 2'h0, 1'b0);
        run(OP_WRITE, 2'h3, 2'h0, 2'h0, 1'b0);
        run(OP_READ, 2'h0, 2'h3, 2'h0, 1'b0);
        $display("refused command test done");
        write_chk(2'h1, 2'h1);
        mreset(2'h1, 15);
        read_chk(2'h1, 2'h1);
        $display("reset after write test done");
        results();
    end
endmodule // flag_offset_serial_loader_tb
